// ### inc/adc_link_regs.svh
// Constants for the converter serial control port and its host controller
`ifndef ADC_LINK_REGS_SVH
`define ADC_LINK_REGS_SVH
`define FRAME_EDGES 5'd16
`define CMD_EDGES 5'd4
`define CMD_WRITE_CFG 4'hA
`define CMD_READ_CFG 4'h9
`define CFG_CLK_SCLK_BIT 10
`define CFG_PIN_INT_BIT 7
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define CFG_RESET 12'h000
`define CONV_MODE_EOC 2'h0
`define CONV_COUNT 8'd14
`define ACLK_NS 4
`define SCLK_PERIOD_NS 160
`define SCLK_HALF_CYC ((`SCLK_PERIOD_NS / 2 + `ACLK_NS - 1) / `ACLK_NS)
`define REG_TX 4'h0
`define REG_CTRL 4'h4
`define REG_STATUS 4'h8
`define REG_RX 4'hC
`define CTRL_RESET 32'h0000_0006
`define CTRL_USE_SYNC 0
`define CTRL_START_PIN 1
`define CTRL_POWER_PIN 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### inc/adc_link_pkg.sv
// Types and shared helpers for both ends of the converter serial link
package adc_link_pkg;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SAMPLE = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PRE = 3'b001,
    H_SELECT = 3'b010,
    H_SYNC_HIGH = 3'b011,
    H_CLOCK = 3'b100,
    H_END = 3'b101
  } host_state_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] prev;
    logic sync_mode;
    logic shift_en;
    logic frame_on;
    logic [4:0] edge_cnt;
    logic [15:0] in_word;
    logic [15:0] out_word;
    logic [3:0] command;
    logic command_valid;
    logic [11:0] configuration_register;
    conv_state_t conv;
    logic [7:0] conv_cnt;
    logic [11:0] result;
    logic result_ready;
    logic status_out_n;
    logic powered_down;
    logic sdo;
    logic sdo_oe;
  } device_regs_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    host_state_t st;
    logic [7:0] div;
    logic [5:0] toggles;
    logic [4:0] nbits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [31:0] ctrl;
    logic done;
    logic chip_select_n;
    logic sclk;
    logic sdi;
    logic frame_sync_input;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_regs_t;

  // Bit i of a frame, counted from the most significant end
  function automatic logic word_bit(input logic [15:0] w, input logic [4:0] i);
    word_bit = w[~i[3:0]];
  endfunction
endpackage

// ### inc/adc_link_if.sv
// Serial pins between the converter control port and its host controller
interface adc_link_if;
  logic chip_select_n;
  logic sclk;
  logic sdi;
  logic frame_sync_input;
  logic conversion_start_pin;
  logic power_down_pin;
  logic sdo;
  logic sdo_oe;
  logic status_out_n;
  logic sdo_line;

  // Released output reads high through a pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport device (
    input chip_select_n, sclk, sdi, frame_sync_input,
    input conversion_start_pin, power_down_pin,
    output sdo, sdo_oe, status_out_n
  );

  modport host (
    output chip_select_n, sclk, sdi, frame_sync_input,
    output conversion_start_pin, power_down_pin,
    input sdo_line, status_out_n
  );
endinterface

// ### rtl/adc_port_device.sv
// Converter end: framing, command shifting, sampling, conversion and status pin
`include "adc_link_regs.svh"
module adc_port_device #(
  parameter bit four_channel = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  adc_link_if.device link,
  // Converter core side
  input wire logic [11:0] analog_code,
  output logic [3:0] command,
  output logic command_valid,
  output logic [11:0] configuration_register,
  output logic sampling,
  output logic converting,
  output logic result_ready,
  output logic powered_down
);
  localparam int CS = 0;
  localparam int SC = 1;
  localparam int DI = 2;
  localparam int FSY = 3;
  localparam int CST = 4;
  localparam int PD = 5;

  adc_link_pkg::device_regs_t r;
  adc_link_pkg::device_regs_t next_r;

  // Commands for the upper four channels are absent on the small variant
  function automatic logic cmd_supported(input logic [3:0] c, input logic narrow);
    cmd_supported = !(narrow && c >= 4'h4 && c <= 4'h7);
  endfunction

  logic [5:0] s;
  logic cs_fall;
  logic cs_rise;
  logic fs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic cst_fall;
  logic cst_rise;
  logic latch;
  logic [15:0] shifted;
  logic conv_tick;
  logic conv_done;
  logic eoc_mode;
  logic int_mode;

  always_comb
  begin
    next_r = r;
    s = r.sync2;
    cs_fall = r.prev[CS] & ~s[CS];
    cs_rise = ~r.prev[CS] & s[CS];
    fs_fall = r.prev[FSY] & ~s[FSY];
    sclk_rise = ~r.prev[SC] & s[SC];
    sclk_fall = r.prev[SC] & ~s[SC];
    cst_fall = r.prev[CST] & ~s[CST];
    cst_rise = ~r.prev[CST] & s[CST];
    shifted = {r.in_word[14:0], s[DI]};
    conv_tick = 1'b0;
    conv_done = 1'b0;

    next_r.sync1 = {link.power_down_pin, link.conversion_start_pin,
                    link.frame_sync_input, link.sdi, link.sclk, link.chip_select_n};
    next_r.sync2 = r.sync1;
    next_r.prev = r.sync2;
    next_r.command_valid = 1'b0;
    next_r.result_ready = 1'b0;

    // Latching polarity follows the mode picked at the select fall
    latch = r.sync_mode ? sclk_fall : sclk_rise;

    if (cs_fall)
    begin
      next_r.sync_mode = ~s[FSY];
      next_r.edge_cnt = 5'h00;
      next_r.shift_en = s[FSY];
      next_r.frame_on = s[FSY];
      next_r.out_word = {r.result, 4'h0};
    end
    else if (fs_fall)
    begin
      next_r.edge_cnt = 5'h00;
      next_r.shift_en = 1'b1;
      next_r.frame_on = 1'b1;
      next_r.out_word = {r.result, 4'h0};
    end
    else if (cs_rise)
    begin
      next_r.shift_en = 1'b0;
      next_r.frame_on = 1'b0;
    end
    else if (latch && r.shift_en)
    begin
      next_r.in_word = shifted;
      next_r.edge_cnt = r.edge_cnt + 5'h01;
      if (r.edge_cnt == `CMD_EDGES - 5'h01)
      begin
        next_r.command = shifted[3:0];
        next_r.command_valid = cmd_supported(shifted[3:0], four_channel);
        if (shifted[3:0] == `CMD_READ_CFG)
        begin
          next_r.out_word = {r.out_word[15:12], r.configuration_register};
        end
      end
      if (r.edge_cnt == `FRAME_EDGES - 5'h01)
      begin
        next_r.shift_en = 1'b0;
        if (r.command == `CMD_WRITE_CFG)
        begin
          next_r.configuration_register = shifted[11:0];
        end
      end
    end

    // Output follows the counter and lets go after the sixteenth bit
    next_r.sdo = adc_link_pkg::word_bit(next_r.out_word, next_r.edge_cnt);
    next_r.sdo_oe = ~s[CS] & next_r.frame_on & ~next_r.edge_cnt[4];

    // Conversion clock is this clock or the serial clock
    conv_tick = r.configuration_register[`CFG_CLK_SCLK_BIT] ? sclk_rise : 1'b1;

    case (r.conv)
      adc_link_pkg::CONV_IDLE:
      begin
        // Early start pin with select low only takes effect at select high
        if (!r.powered_down && s[CS] && !s[CST])
        begin
          next_r.conv = adc_link_pkg::CONV_SAMPLE;
        end
      end
      adc_link_pkg::CONV_SAMPLE:
      begin
        if (cst_rise && s[CS])
        begin
          next_r.conv = adc_link_pkg::CONV_RUN;
          next_r.conv_cnt = 8'h00;
        end
        else if (!s[CS])
        begin
          next_r.conv = adc_link_pkg::CONV_IDLE;
        end
      end
      adc_link_pkg::CONV_RUN:
      begin
        if (conv_tick)
        begin
          next_r.conv_cnt = r.conv_cnt + 8'h01;
          if (r.conv_cnt == `CONV_COUNT - 8'h01)
          begin
            next_r.conv = adc_link_pkg::CONV_IDLE;
            next_r.result = analog_code;
            next_r.result_ready = 1'b1;
            conv_done = 1'b1;
          end
        end
      end
      default:
      begin
        next_r.conv = adc_link_pkg::CONV_IDLE;
      end
    endcase

    // Power-down aborts sampling and conversion, not serial shifting; a select, sync or start fall wakes it
    if (!s[PD])
    begin
      next_r.powered_down = 1'b1;
      next_r.conv = adc_link_pkg::CONV_IDLE;
    end
    else if (r.powered_down && (cs_fall || fs_fall || cst_fall))
    begin
      next_r.powered_down = 1'b0;
    end

    eoc_mode = !r.configuration_register[`CFG_PIN_INT_BIT] &&
      (r.configuration_register[`CFG_MODE_HI:`CFG_MODE_LO] == `CONV_MODE_EOC);
    int_mode = r.configuration_register[`CFG_PIN_INT_BIT];

    if (eoc_mode)
    begin
      next_r.status_out_n = !(next_r.conv == adc_link_pkg::CONV_RUN);
    end
    else if (int_mode)
    begin
      // Data ready wins over a clearing frame start in the same cycle
      if (conv_done)
      begin
        next_r.status_out_n = 1'b0;
      end
      else if (cs_fall || fs_fall)
      begin
        next_r.status_out_n = 1'b1;
      end
    end
    else
    begin
      next_r.status_out_n = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Synchronisers start at each pin's idle level, so reset leaves no false edge
      r <= '{sync1: 6'h39, sync2: 6'h39, prev: 6'h39, sync_mode: 1'b0, shift_en: 1'b0,
             frame_on: 1'b0, edge_cnt: 5'h10, in_word: 16'h0000, out_word: 16'h0000,
             command: 4'h0, command_valid: 1'b0, configuration_register: `CFG_RESET,
             conv: adc_link_pkg::CONV_IDLE, conv_cnt: 8'h00, result: 12'h000,
             result_ready: 1'b0, status_out_n: 1'b1, powered_down: 1'b0,
             sdo: 1'b0, sdo_oe: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.sdo = r.sdo;
  assign link.sdo_oe = r.sdo_oe;
  assign link.status_out_n = r.status_out_n;
  assign command = r.command;
  assign command_valid = r.command_valid;
  assign configuration_register = r.configuration_register;
  assign sampling = (r.conv == adc_link_pkg::CONV_SAMPLE);
  assign converting = (r.conv == adc_link_pkg::CONV_RUN);
  assign result_ready = r.result_ready;
  assign powered_down = r.powered_down;
endmodule

// ### rtl/adc_port_host.sv
// Host end: AXI4-Lite registers driving one serial frame at a time
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`include "adc_link_regs.svh"
module adc_port_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  adc_link_if.host link
);
  localparam logic [7:0] HALF = 8'(`SCLK_HALF_CYC);

  adc_link_pkg::host_regs_t r;
  adc_link_pkg::host_regs_t next_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++)
    begin
      if (b[i])
      begin
        o[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = o;
  endfunction

  logic half;
  logic busy;
  logic do_write;
  logic start;
  logic latch_edge;
  logic [31:0] wv;

  always_comb
  begin
    next_r = r;
    next_r.sync1 = {link.status_out_n, link.sdo_line};
    next_r.sync2 = r.sync1;
    half = (r.div == HALF - 8'h01);
    busy = (r.st != adc_link_pkg::H_IDLE);
    start = 1'b0;
    latch_edge = 1'b0;
    wv = 32'h0000_0000;

    // Write: address and data taken in either order, then one response
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    do_write = r.aw_got && r.w_got && !r.bvalid;
    if (do_write)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `RESP_OKAY;
      case (r.aw_addr)
        `REG_TX:
        begin
          // Ignored while a frame is in flight
          if (!busy)
          begin
            wv = merge({16'h0000, r.tx}, r.w_data, r.w_strb);
            next_r.tx = wv[15:0];
            start = 1'b1;
          end
        end
        `REG_CTRL:
        begin
          next_r.ctrl = merge(r.ctrl, r.w_data, r.w_strb) & 32'h0000_0007;
        end
        `REG_STATUS, `REG_RX:
        begin
          next_r.bresp = `RESP_OKAY;
        end
        default:
        begin
          next_r.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_TX: next_r.rdata = {16'h0000, r.tx};
        `REG_CTRL: next_r.rdata = r.ctrl;
        `REG_STATUS: next_r.rdata = {29'h0, r.sync2[1], r.done, busy};
        `REG_RX: next_r.rdata = {16'h0000, r.rx};
        default:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end

    // Frame sequencer, one step per half serial clock period
    next_r.div = (busy && !half) ? r.div + 8'h01 : 8'h00;
    case (r.st)
      adc_link_pkg::H_IDLE:
      begin
        next_r.sclk = 1'b0;
        if (start)
        begin
          next_r.done = 1'b0;
          next_r.frame_sync_input = ~r.ctrl[`CTRL_USE_SYNC];
          next_r.st = adc_link_pkg::H_PRE;
        end
      end
      adc_link_pkg::H_PRE:
      begin
        if (half)
        begin
          next_r.chip_select_n = 1'b0;
          next_r.sdi = r.tx[15];
          next_r.toggles = 6'h00;
          next_r.nbits = 5'h00;
          next_r.st = adc_link_pkg::H_SELECT;
        end
      end
      adc_link_pkg::H_SELECT:
      begin
        if (half)
        begin
          next_r.frame_sync_input = 1'b1;
          next_r.st = r.ctrl[`CTRL_USE_SYNC] ? adc_link_pkg::H_SYNC_HIGH
                                             : adc_link_pkg::H_CLOCK;
        end
      end
      adc_link_pkg::H_SYNC_HIGH:
      begin
        if (half)
        begin
          next_r.frame_sync_input = 1'b0;
          next_r.st = adc_link_pkg::H_CLOCK;
        end
      end
      adc_link_pkg::H_CLOCK:
      begin
        if (half)
        begin
          next_r.sclk = ~r.sclk;
          next_r.toggles = r.toggles + 6'h01;
          latch_edge = r.ctrl[`CTRL_USE_SYNC] ? r.sclk : ~r.sclk;
          if (latch_edge)
          begin
            next_r.rx = {r.rx[14:0], r.sync2[0]};
            next_r.nbits = r.nbits + 5'h01;
          end
          else if (!r.nbits[4])
          begin
            next_r.sdi = adc_link_pkg::word_bit(r.tx, r.nbits);
          end
          if (r.toggles == 6'h1F)
          begin
            next_r.st = adc_link_pkg::H_END;
          end
        end
      end
      adc_link_pkg::H_END:
      begin
        if (half)
        begin
          next_r.chip_select_n = 1'b1;
          next_r.done = 1'b1;
          next_r.st = adc_link_pkg::H_IDLE;
        end
      end
      default:
      begin
        next_r.st = adc_link_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '{sync1: 2'h3, sync2: 2'h3, st: adc_link_pkg::H_IDLE, div: 8'h00,
             toggles: 6'h00, nbits: 5'h00, tx: 16'h0000, rx: 16'h0000,
             ctrl: `CTRL_RESET, done: 1'b0, chip_select_n: 1'b1, sclk: 1'b0,
             sdi: 1'b0, frame_sync_input: 1'b1, aw_got: 1'b0, w_got: 1'b0,
             aw_addr: 4'h0, w_data: 32'h0000_0000, w_strb: 4'h0, bvalid: 1'b0,
             bresp: 2'h0, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'h0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign link.chip_select_n = r.chip_select_n;
  assign link.sclk = r.sclk;
  assign link.sdi = r.sdi;
  assign link.frame_sync_input = r.frame_sync_input;
  assign link.conversion_start_pin = r.ctrl[`CTRL_START_PIN];
  assign link.power_down_pin = r.ctrl[`CTRL_POWER_PIN];
endmodule

// ### tb/adc_link_assertions.sv
// Checker for framing, edge counting and serial clock use on the link pins
module adc_link_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_sync_input,
  input wire logic sdo_oe,
  input wire logic status_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_sclk;
  logic prev_cs;
  logic prev_fs;
  logic mode;
  logic [4:0] cnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Latching edges of the frame, polarity picked by the sync level at select fall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_sclk <= 1'b0;
      prev_cs <= 1'b1;
      prev_fs <= 1'b1;
      mode <= 1'b0;
      cnt <= 5'd0;
    end
    else
    begin
      prev_sclk <= sclk;
      prev_cs <= chip_select_n;
      prev_fs <= frame_sync_input;
      if (prev_cs && !chip_select_n)
      begin
        cnt <= 5'd0;
        mode <= !frame_sync_input;
      end
      else if (prev_fs && !frame_sync_input)
        cnt <= 5'd0;
      else if (!chip_select_n && cnt != 5'd16 &&
               (mode ? (prev_sclk && !sclk) : (!prev_sclk && sclk)))
        cnt <= cnt + 5'd1;
    end
  end

  release_on_select_a: assert property ($rose(chip_select_n) |-> ##[0:6] !sdo_oe)
    else $error("output still driven after select rise");
  release_at_sixteen_a: assert property (
    $rose(cnt == 5'd16) |-> ##[1:6] !sdo_oe)
    else $error("output still driven after sixteen edges");
  plain_frame_open_a: assert property (
    $fell(chip_select_n) && frame_sync_input |-> ##[1:6] sdo_oe)
    else $error("plain frame did not enable output");
  sync_frame_wait_a: assert property (
    $fell(chip_select_n) && !frame_sync_input |-> !sdo_oe [*8])
    else $error("sync frame enabled before sync pulse");
  sync_fall_open_a: assert property (
    $fell(frame_sync_input) && !chip_select_n |-> ##[1:6] sdo_oe)
    else $error("sync fall did not enable output");
  select_sclk_low_a: assert property ($changed(chip_select_n) |-> !sclk)
    else $error("select moved while serial clock high");
  sclk_idle_low_a: assert property (chip_select_n && $past(chip_select_n) |-> !sclk)
    else $error("serial clock not idle low");
  plain_sdi_setup_a: assert property (!mode && !chip_select_n && $changed(sdi) |-> !sclk)
    else $error("input bit changed while serial clock high");
  status_fall_idle_a: assert property ($fell(status_out_n) |-> chip_select_n)
    else $error("status fell inside a frame");

  cover property ($rose(cnt == 5'd16) && !mode);
  cover property ($rose(cnt == 5'd16) && mode);
  cover property ($fell(status_out_n));
endmodule

// ### tb/adc_serial_control_port_tb_top.sv
// Testbench joining host and converter ends over the link, driven through AXI4-Lite
`include "adc_link_regs.svh"
module adc_serial_control_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] ctrl;
    logic [15:0] tx;
    logic [11:0] exp;
    logic rd;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [11:0] analog_code = 12'hABC;
  logic [3:0] command;
  logic command_valid;
  logic [11:0] configuration_register;
  logic sampling;
  logic converting;
  logic result_ready;
  logic powered_down;
  logic [15:0] rise_sh = 16'h0;
  logic [15:0] fall_sh = 16'h0;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [7:0] n;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_valid = 0;
  row_t rows [5] = '{
    '{32'h6, 16'hA0A5, 12'h0A5, 1'b0}, '{32'h6, 16'h9000, 12'h0A5, 1'b1},
    '{32'h7, 16'hA123, 12'h123, 1'b0}, '{32'h7, 16'h9000, 12'h123, 1'b1},
    '{32'h6, 16'hA000, 12'h000, 1'b0}};

  adc_link_if link();
  adc_port_device adc_port_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
    .analog_code(analog_code), .command(command), .command_valid(command_valid),
    .configuration_register(configuration_register), .sampling(sampling),
    .converting(converting), .result_ready(result_ready), .powered_down(powered_down));
  adc_port_host adc_port_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link(link));
  adc_link_assertions adc_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
    .chip_select_n(link.chip_select_n), .sclk(link.sclk), .sdi(link.sdi),
    .frame_sync_input(link.frame_sync_input), .sdo_oe(link.sdo_oe),
    .status_out_n(link.status_out_n));

  always #2 aclk = ~aclk;
  // Bits seen on the wire at each clock polarity while selected
  always @(posedge link.sclk) if (!link.chip_select_n) rise_sh <= {rise_sh[14:0], link.sdi};
  always @(negedge link.sclk) if (!link.chip_select_n) fall_sh <= {fall_sh[14:0], link.sdi};
  // Decoded command pulses, one per frame
  always @(posedge aclk) if (command_valid === 1'b1) n_valid++;

  task automatic report_and_stop();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One frame: start it, wait for done, fetch the received word
  task automatic frame(input logic [15:0] tx);
    axi_write(`REG_TX, {16'h0, tx});
    rd = 32'h0;
    for (int k = 0; k < 500 && rd[1] !== 1'b1; k++) axi_read(`REG_STATUS);
    chk(rd[1], 1'b1);
    axi_read(`REG_RX);
  endtask

  // Sampling window by the start pin, then wait for the result
  // Status pin is low mid-run only in end-of-conversion mode
  task automatic convert(input logic eoc);
    axi_write(`REG_CTRL, 32'h4);
    repeat (10) @(posedge aclk);
    chk(sampling, 1'b1);
    axi_write(`REG_CTRL, 32'h6);
    n = 8'd0;
    for (int k = 0; k < 200 && result_ready !== 1'b1; k++)
    begin
      @(posedge aclk);
      #1;
      if (converting === 1'b1) n++;
      if (n == 8'd4) chk(link.status_out_n, !eoc);
    end
    chk(n >= `CONV_COUNT && n <= `CONV_COUNT + 8'd1, 1'b1);
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(link.sdo_oe, 1'b0);
    chk(configuration_register, `CFG_RESET);
    axi_read(`REG_CTRL);
    chk(rd, `CTRL_RESET);
    axi_read(4'h2);
    chk(resp, `RESP_SLVERR);
    foreach (rows[i])
    begin
      axi_write(`REG_CTRL, rows[i].ctrl);
      frame(rows[i].tx);
      chk(command, rows[i].tx[15:12]);
      if (rows[i].rd) chk(rd[11:0], rows[i].exp);
      else chk(configuration_register, rows[i].exp);
      if (rows[i].ctrl[0]) chk(fall_sh, rows[i].tx);
      else chk(rise_sh, rows[i].tx);
    end
    chk(n_valid, 32'd5);
    convert(1'b1);
    repeat (3) @(posedge aclk);
    chk(link.status_out_n, 1'b1);
    frame(16'h1000);
    chk(rd[15:0], {analog_code, 4'h0});
    frame(16'hA080);
    convert(1'b0);
    repeat (6) @(posedge aclk);
    chk(link.status_out_n, 1'b0);
    axi_read(`REG_STATUS);
    chk(rd[2], 1'b0);
    frame(16'h1000);
    chk(link.status_out_n, 1'b1);
    // Start pin low through a frame: sampling waits for select high
    axi_write(`REG_CTRL, 32'h4);
    axi_write(`REG_TX, 32'h0000_1000);
    repeat (60) @(posedge aclk);
    chk(sampling, 1'b0);
    repeat (800) @(posedge aclk);
    chk(sampling, 1'b1);
    axi_write(`REG_CTRL, 32'h2);
    repeat (6) @(posedge aclk);
    chk(powered_down, 1'b1);
    axi_write(`REG_CTRL, 32'h6);
    frame(16'h1000);
    chk(powered_down, 1'b0);
    report_and_stop();
  end
endmodule
